/* File: rtl/cps_sched.v */
`timescale 1ns/10ps
`include "cps_consts.vh"
// Summary of operation
// - accept writes, answer reads of configs
// - permanent byte selects volatile or retained
// - timer packet id 180, four bytes
// - utc byte locks ticks to seconds
// - timer period 1000 to 65535 microseconds
// - tick rate is million over period
// - period packet id 181, entries five bytes
// - clear byte deletes all schedules first
// - one period per id, newer replaces
// - packet emitted every period ticks
// - baud packet id 182, seventeen bytes
// - baud limits per port checked
// - alignment packet id 185, 73 bytes
module cps_sched #(
  parameter NSLOT = 8,
  parameter SW    = 3
) (
  // clock and reset
  input  wire        sys_clk_in,
  input  wire        resetn_in,
  input  wire        ce_in,
  // packet in: id byte first, then payload
  input  wire        rx_valid_in,
  input  wire [7:0]  rx_data_in,
  input  wire        rx_last_in,
  output reg         rx_ready_out,
  // answer stream
  output wire        tx_valid_out,
  output wire [7:0]  tx_data_out,
  output wire        tx_last_out,
  input  wire        tx_ready_in,
  // status pulses
  output reg         accept_out,
  output reg         reject_out,
  output reg         save_req_out,
  output reg  [7:0]  save_id_out,
  // time base
  input  wire        pps_in,
  output wire        tick_out,
  output reg         emit_valid_out,
  output reg  [7:0]  emit_id_out,
  // applied settings
  output reg  [15:0] timer_period_out,
  output reg         utc_sync_out,
  output reg  [31:0] baud_primary_out,
  output reg  [31:0] baud_gpio_out,
  output reg  [31:0] baud_aux_out,
  output reg  [3:0]  retain_out,
  input  wire [4:0]  align_idx_in,
  output reg  [31:0] align_word_out
);
  localparam [3:0] S_RECV  = 4'b0001;
  localparam [3:0] S_CHK   = 4'b0010;
  localparam [3:0] S_APPLY = 4'b0100;
  localparam [3:0] S_SEND  = 4'b1000;

  reg  [3:0]  state_r;
  reg  [7:0]  id_r;
  reg         have_id_r;
  reg  [6:0]  cnt_r;
  reg         ovf_r;
  reg  [7:0]  buf_r [0:`CPS_BUF_BYTES-1];
  reg  [7:0]  align_r [0:`CPS_LEN_ALIGN-2];
  reg  [6:0]  ptr_r;
  reg  [6:0]  end_r;
  reg  [SW:0] slot_r;
  reg  [2:0]  sub_r;
  reg         in_ent_r;

  // schedule table
  reg  [NSLOT-1:0] sv_r;
  reg  [7:0]       sid_r  [0:NSLOT-1];
  reg  [31:0]      sper_r [0:NSLOT-1];
  reg  [31:0]      scnt_r [0:NSLOT-1];
  reg  [NSLOT-1:0] pend_r;
  reg  [NSLOT-1:0] slot_wr;
  reg              clr_all_r;
  wire [7:0]       ent_id;
  wire [31:0]      ent_per;
  reg  [NSLOT-1:0] hit;
  reg  [NSLOT-1:0] freev;
  reg  [NSLOT-1:0] emit_sel;
  reg  [NSLOT-1:0] nxt_valid;
  wire [8:0]       f_in;
  wire             f_ready;
  reg              f_valid;
  reg  [7:0]       f_data;
  reg              f_last;
  reg              len_ok;
  reg              rng_ok;
  wire [15:0]      new_tper;
  wire [31:0]      new_bp;
  wire [31:0]      new_bg;
  wire [31:0]      new_ba;
  integer          i;
  integer          j;

  function [31:0] le32;
    input [6:0] ofs;
    begin
      le32 = {buf_r[ofs+7'd3], buf_r[ofs+7'd2],
              buf_r[ofs+7'd1], buf_r[ofs]};
    end
  endfunction

  function [7:0] byte_of;
    input [31:0] w;
    input [1:0]  k;
    begin
      byte_of = w[8*k +: 8];
    end
  endfunction

  assign new_tper = {buf_r[`CPS_OFS_TPER+1], buf_r[`CPS_OFS_TPER]};
  assign new_bp   = le32(`CPS_OFS_BAUD_PRI);
  assign new_bg   = le32(`CPS_OFS_BAUD_GPIO);
  assign new_ba   = le32(`CPS_OFS_BAUD_AUX);
  assign ent_id   = buf_r[ptr_r];
  assign ent_per  = le32(ptr_r + 7'd1);

  // length and range screen on a finished write
  always @*
  begin
    len_ok = !ovf_r;
    rng_ok = (buf_r[`CPS_OFS_PERM] <= 8'h01);
    case (id_r)
      `CPS_ID_TIMER:
      begin
        len_ok = len_ok && (cnt_r == `CPS_LEN_TIMER);
        rng_ok = rng_ok && (buf_r[`CPS_OFS_UTC] <= 8'h01)
                 && (new_tper >= `CPS_TPER_MIN);
      end
      `CPS_ID_PERIODS:
      begin
        len_ok = len_ok && (cnt_r >= `CPS_LEN_PER_HDR)
                 && ((cnt_r - `CPS_LEN_PER_HDR) % `CPS_LEN_ENTRY
                     == 7'h00);
        rng_ok = rng_ok && (buf_r[`CPS_OFS_CLEAR] <= 8'h01);
      end
      `CPS_ID_BAUD:
      begin
        len_ok = len_ok && (cnt_r == `CPS_LEN_BAUD);
        rng_ok = rng_ok
          && (new_bp >= `CPS_BAUD_MIN) && (new_bp <= `CPS_BAUD_PRI_MAX)
          && (new_bg >= `CPS_BAUD_MIN) && (new_bg <= `CPS_BAUD_GPIO_MAX)
          && (new_ba >= `CPS_BAUD_MIN)
          && (new_ba <= `CPS_BAUD_AUX_MAX);
      end
      `CPS_ID_ALIGN:
        len_ok = len_ok && (cnt_r == `CPS_LEN_ALIGN);
      default:
        len_ok = 1'b0;
    endcase
  end

  // slot lookup: a matching id wins over the first free slot
  always @*
  begin
    slot_wr = {NSLOT{1'b0}};
    for (i = 0; i < NSLOT; i = i + 1)
    begin
      hit[i]   = sv_r[i] && (sid_r[i] == ent_id);
      freev[i] = !sv_r[i];
    end
    if (state_r == S_APPLY && ptr_r < end_r && !clr_all_r)
    begin
      if (|hit)
        slot_wr = hit;
      else
        slot_wr = freev & (~freev + 1'b1);
    end
    emit_sel = pend_r & (~pend_r + 1'b1);
    // mask of all valid slots at or after slot_r, for the read answer
    nxt_valid = {NSLOT{1'b0}};
    for (i = 0; i < NSLOT; i = i + 1)
      nxt_valid[i] = sv_r[i] && (i >= slot_r);
  end

  genvar g;
  generate
    for (g = 0; g < NSLOT; g = g + 1)
    begin : g_slot
      always @(posedge sys_clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
        begin
          sv_r[g]   <= 1'b0;
          sid_r[g]  <= 8'h00;
          sper_r[g] <= 32'h0000_0000;
          scnt_r[g] <= 32'h0000_0000;
          pend_r[g] <= 1'b0;
        end
        else if (ce_in)
        begin
          if (clr_all_r)
            sv_r[g] <= 1'b0;
          else if (slot_wr[g])
          begin
            // a zero period stops the identifier
            sv_r[g]   <= (ent_per != 32'h0000_0000);
            sid_r[g]  <= ent_id;
            sper_r[g] <= ent_per;
            scnt_r[g] <= 32'h0000_0000;
          end
          else if (tick_out && sv_r[g])
          begin
            if (scnt_r[g] + 32'h0000_0001 >= sper_r[g])
              scnt_r[g] <= 32'h0000_0000;
            else
              scnt_r[g] <= scnt_r[g] + 32'h0000_0001;
          end
          // a new due event wins over the clear by emission
          if (tick_out && sv_r[g] && !slot_wr[g] && !clr_all_r
              && scnt_r[g] + 32'h0000_0001 >= sper_r[g])
            pend_r[g] <= 1'b1;
          else if (emit_sel[g] || clr_all_r)
            pend_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // read answer bytes, pushed into the fifo
  always @*
  begin
    f_valid = 1'b0;
    f_data  = 8'h00;
    f_last  = 1'b0;
    if (state_r == S_SEND)
    begin
      f_valid = 1'b1;
      f_last  = (ptr_r == end_r);
      if (ptr_r == 7'h00)
        f_data = id_r;
      else
        case (id_r)
          `CPS_ID_TIMER:
            case (ptr_r)
              7'h01:   f_data = {7'h00, retain_out[0]};
              7'h02:   f_data = {7'h00, utc_sync_out};
              7'h03:   f_data = timer_period_out[7:0];
              default: f_data = timer_period_out[15:8];
            endcase
          `CPS_ID_BAUD:
            if (ptr_r == 7'h01)
              f_data = {7'h00, retain_out[2]};
            else if (ptr_r < 7'h06)
              f_data = byte_of(baud_primary_out, ptr_r[1:0] - 2'b10);
            else if (ptr_r < 7'h0A)
              f_data = byte_of(baud_gpio_out, ptr_r[1:0] - 2'b10);
            else if (ptr_r < 7'h0E)
              f_data = byte_of(baud_aux_out, ptr_r[1:0] - 2'b10);
            else
              f_data = 8'h00;
          `CPS_ID_ALIGN:
            if (ptr_r == 7'h01)
              f_data = {7'h00, retain_out[3]};
            else
              f_data = align_r[ptr_r - 7'h02];
          default:
          begin
            f_last = 1'b0;
            if (!in_ent_r)
              f_data = (ptr_r == 7'h01) ? {7'h00, retain_out[1]} : 8'h00;
            else if (!sv_r[slot_r[SW-1:0]])
              f_valid = 1'b0;
            else
            begin
              f_data = (sub_r == 3'h0) ? sid_r[slot_r[SW-1:0]]
                       : byte_of(sper_r[slot_r[SW-1:0]],
                                 sub_r[1:0] - 2'b01);
              f_last = (sub_r == 3'h4)
                       && ((nxt_valid >> (slot_r + 1'b1)) == 0);
            end
            if (!in_ent_r && ptr_r == 7'h02 && sv_r == {NSLOT{1'b0}})
              f_last = 1'b1;
          end
        endcase
    end
  end

  assign f_in = {f_last, f_data};

  always @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_r          <= S_RECV;
      rx_ready_out     <= 1'b0;
      id_r             <= 8'h00;
      have_id_r        <= 1'b0;
      cnt_r            <= 7'h00;
      ovf_r            <= 1'b0;
      ptr_r            <= 7'h00;
      end_r            <= 7'h00;
      slot_r           <= {(SW+1){1'b0}};
      sub_r            <= 3'h0;
      in_ent_r         <= 1'b0;
      clr_all_r        <= 1'b0;
      accept_out       <= 1'b0;
      reject_out       <= 1'b0;
      save_req_out     <= 1'b0;
      save_id_out      <= 8'h00;
      emit_valid_out   <= 1'b0;
      emit_id_out      <= 8'h00;
      timer_period_out <= `CPS_TPER_RST;
      utc_sync_out     <= 1'b0;
      baud_primary_out <= `CPS_BAUD_RST;
      baud_gpio_out    <= `CPS_BAUD_RST;
      baud_aux_out     <= `CPS_BAUD_RST;
      retain_out       <= 4'h0;
      align_word_out   <= 32'h0000_0000;
      for (j = 0; j < `CPS_LEN_ALIGN - 1; j = j + 1)
        align_r[j] <= 8'h00;
    end
    else if (ce_in)
    begin
      accept_out     <= 1'b0;
      reject_out     <= 1'b0;
      save_req_out   <= 1'b0;
      clr_all_r      <= 1'b0;
      emit_valid_out <= |pend_r;
      for (j = 0; j < NSLOT; j = j + 1)
        if (emit_sel[j])
          emit_id_out <= sid_r[j];
      align_word_out <= {align_r[{align_idx_in, 2'b11}],
                         align_r[{align_idx_in, 2'b10}],
                         align_r[{align_idx_in, 2'b01}],
                         align_r[{align_idx_in, 2'b00}]};
      case (state_r)
        S_RECV:
        begin
          rx_ready_out <= 1'b1;
          if (rx_valid_in && rx_ready_out)
          begin
            if (!have_id_r)
              id_r <= rx_data_in;
            else if (cnt_r == `CPS_BUF_BYTES)
              ovf_r <= 1'b1;
            else
            begin
              buf_r[cnt_r] <= rx_data_in;
              cnt_r        <= cnt_r + 7'h01;
            end
            have_id_r <= !rx_last_in;
            if (rx_last_in)
            begin
              rx_ready_out <= 1'b0;
              state_r      <= S_CHK;
            end
          end
        end
        S_CHK:
        begin
          ptr_r <= 7'h00;
          if (cnt_r == 7'h00 && !ovf_r)
          begin
            // an empty payload is a read of that packet
            in_ent_r <= 1'b0;
            slot_r   <= {(SW+1){1'b0}};
            sub_r    <= 3'h0;
            case (id_r)
              `CPS_ID_TIMER:  end_r <= `CPS_LEN_TIMER;
              `CPS_ID_BAUD:   end_r <= `CPS_LEN_BAUD;
              `CPS_ID_ALIGN:  end_r <= `CPS_LEN_ALIGN;
              default:        end_r <= `CPS_LEN_PER_HDR;
            endcase
            if (id_r == `CPS_ID_TIMER || id_r == `CPS_ID_PERIODS
                || id_r == `CPS_ID_BAUD || id_r == `CPS_ID_ALIGN)
              state_r <= S_SEND;
            else
            begin
              reject_out <= 1'b1;
              state_r    <= S_RECV;
            end
          end
          else if (!(len_ok && rng_ok))
          begin
            reject_out <= 1'b1;
            state_r    <= S_RECV;
          end
          else
          begin
            accept_out   <= 1'b1;
            save_req_out <= (buf_r[`CPS_OFS_PERM] == 8'h01);
            save_id_out  <= id_r;
            state_r      <= S_RECV;
            case (id_r)
              `CPS_ID_TIMER:
              begin
                retain_out[0]    <= buf_r[`CPS_OFS_PERM][0];
                utc_sync_out     <= buf_r[`CPS_OFS_UTC][0];
                timer_period_out <= new_tper;
              end
              `CPS_ID_PERIODS:
              begin
                retain_out[1] <= buf_r[`CPS_OFS_PERM][0];
                clr_all_r     <= buf_r[`CPS_OFS_CLEAR][0];
                ptr_r         <= `CPS_LEN_PER_HDR;
                end_r         <= cnt_r;
                state_r       <= S_APPLY;
              end
              `CPS_ID_BAUD:
              begin
                retain_out[2]    <= buf_r[`CPS_OFS_PERM][0];
                baud_primary_out <= new_bp;
                baud_gpio_out    <= new_bg;
                baud_aux_out     <= new_ba;
              end
              default:
              begin
                retain_out[3] <= buf_r[`CPS_OFS_PERM][0];
                for (j = 0; j < `CPS_LEN_ALIGN - 1; j = j + 1)
                  align_r[j] <= buf_r[j + `CPS_OFS_ALIGN];
              end
            endcase
          end
          cnt_r <= 7'h00;
          ovf_r <= 1'b0;
        end
        S_APPLY:
        begin
          // entries land one per cycle; a full table drops new ids
          if (ptr_r >= end_r)
            state_r <= S_RECV;
          else if (!clr_all_r)
            ptr_r <= ptr_r + `CPS_LEN_ENTRY;
        end
        S_SEND:
        begin
          if (f_ready || !f_valid)
          begin
            if (f_last)
              state_r <= S_RECV;
            else if (!in_ent_r)
            begin
              ptr_r <= ptr_r + 7'h01;
              if (id_r == `CPS_ID_PERIODS && ptr_r == end_r)
                in_ent_r <= 1'b1;
            end
            else if (!f_valid || sub_r == 3'h4)
            begin
              sub_r  <= 3'h0;
              slot_r <= slot_r + 1'b1;
            end
            else
              sub_r <= sub_r + 3'h1;
          end
        end
        default:
          state_r <= S_RECV;
      endcase
    end
  end

  cps_tick_gen u_tick (
    .sys_clk_in   (sys_clk_in),
    .resetn_in    (resetn_in),
    .ce_in        (ce_in),
    .period_us_in (timer_period_out),
    .utc_sync_in  (utc_sync_out),
    .pps_in       (pps_in),
    .tick_out     (tick_out)
  );

  cps_fifo #(
    .WIDTH (9),
    .DEPTH (16),
    .AW    (4)
  ) u_fifo (
    .sys_clk_in    (sys_clk_in),
    .resetn_in     (resetn_in),
    .ce_in         (ce_in),
    .in_valid_in   (f_valid),
    .in_data_in    (f_in),
    .in_ready_out  (f_ready),
    .out_valid_out (tx_valid_out),
    .out_data_out  ({tx_last_out, tx_data_out}),
    .out_ready_in  (tx_ready_in)
  );
endmodule // cps_sched

/* File: rtl/cps_consts.vh */
`ifndef CPS_CONSTS_VH
`define CPS_CONSTS_VH
// packet identifiers
`define CPS_ID_TIMER      8'hB4
`define CPS_ID_PERIODS    8'hB5
`define CPS_ID_BAUD       8'hB6
`define CPS_ID_ALIGN      8'hB9
// payload lengths in bytes
`define CPS_LEN_TIMER     7'h04
`define CPS_LEN_BAUD      7'h11
`define CPS_LEN_ALIGN     7'h49
`define CPS_LEN_PER_HDR   7'h02
`define CPS_LEN_ENTRY     7'h05
`define CPS_BUF_BYTES     73
// payload field offsets
`define CPS_OFS_PERM      0
`define CPS_OFS_UTC       1
`define CPS_OFS_TPER      2
`define CPS_OFS_CLEAR     1
`define CPS_OFS_BAUD_PRI  1
`define CPS_OFS_BAUD_GPIO 5
`define CPS_OFS_BAUD_AUX  9
`define CPS_OFS_ALIGN     1
// field ranges
`define CPS_TPER_MIN      16'h03E8
`define CPS_BAUD_MIN      32'h0000_0960
`define CPS_BAUD_PRI_MAX  32'h0098_9680
`define CPS_BAUD_GPIO_MAX 32'h0003_D090
`define CPS_BAUD_AUX_MAX  32'h001E_8480
// reset values
`define CPS_TPER_RST      16'h03E8
`define CPS_BAUD_RST      32'h0001_C200
// timing: one tick of the period is one microsecond
`define CPS_CLK_MHZ       250
`define CPS_US_PER_S      1000000
`endif

/* File: rtl/cps_fifo.v */
`timescale 1ns/10ps
module cps_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire             sys_clk_in,
  input  wire             resetn_in,
  input  wire             ce_in,
  // fill side
  input  wire             in_valid_in,
  input  wire [WIDTH-1:0] in_data_in,
  output wire             in_ready_out,
  // drain side
  output wire             out_valid_out,
  output wire [WIDTH-1:0] out_data_out,
  input  wire             out_ready_in
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  reg [AW:0]      count_r;
  wire            push;
  wire            pop;

  assign in_ready_out  = (count_r != DEPTH[AW:0]);
  assign out_valid_out = (count_r != {(AW+1){1'b0}});
  assign out_data_out  = mem_r[rd_ptr_r];
  assign push = ce_in && in_valid_in && in_ready_out;
  assign pop  = ce_in && out_valid_out && out_ready_in;

  always @(posedge sys_clk_in)
  begin
    if (push)
      mem_r[wr_ptr_r] <= in_data_in;
  end

  always @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                    : wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                    : rd_ptr_r + 1'b1;
      if (push && !pop)
        count_r <= count_r + 1'b1;
      else if (pop && !push)
        count_r <= count_r - 1'b1;
    end
  end
endmodule // cps_fifo

/* File: rtl/cps_tick_gen.v */
`timescale 1ns/10ps
`include "cps_consts.vh"
module cps_tick_gen #(
  parameter CLK_MHZ = `CPS_CLK_MHZ
) (
  // clock and reset
  input  wire        sys_clk_in,
  input  wire        resetn_in,
  input  wire        ce_in,
  // configuration
  input  wire [15:0] period_us_in,
  input  wire        utc_sync_in,
  input  wire        pps_in,
  // tick
  output reg         tick_out
);
  localparam [7:0] CYC_US = CLK_MHZ[7:0];
  reg  [7:0]  us_cnt_r;
  reg  [15:0] per_cnt_r;
  wire        us_end;
  wire        per_end;
  wire        align;

  assign us_end  = (us_cnt_r == CYC_US - 8'h01);
  assign per_end = us_end && (per_cnt_r >= period_us_in - 16'h0001);
  // with utc sync on, a second mark restarts the period so ticks land on whole seconds
  assign align   = utc_sync_in && pps_in;

  always @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      us_cnt_r  <= 8'h00;
      per_cnt_r <= 16'h0000;
      tick_out  <= 1'b0;
    end
    else if (ce_in)
    begin
      tick_out <= per_end || align;
      if (align || us_end)
        us_cnt_r <= 8'h00;
      else
        us_cnt_r <= us_cnt_r + 8'h01;
      if (align || per_end)
        per_cnt_r <= 16'h0000;
      else if (us_end)
        per_cnt_r <= per_cnt_r + 16'h0001;
    end
  end
endmodule // cps_tick_gen

/* File: verif/cps_host_sink.sv */
`timescale 1ns/10ps
module cps_host_sink (
  // clock and reset
  input  wire       sys_clk_in,
  input  wire       resetn_in,
  // answer stream from the block
  input  wire       tx_valid_in,
  input  wire [7:0] tx_data_in,
  input  wire       tx_last_in,
  output reg        tx_ready_out,
  // bytes taken, one cycle late
  output reg        got_out,
  output reg  [7:0] got_data_out,
  output reg        got_last_out
);
  always @(posedge sys_clk_in or negedge resetn_in)
    if (!resetn_in)
    begin
      tx_ready_out <= 1'b0;
      got_out      <= 1'b0;
      got_data_out <= 8'h00;
      got_last_out <= 1'b0;
    end
    else
    begin
      tx_ready_out <= ($urandom % 3) != 0;
      got_out      <= tx_valid_in & tx_ready_out;
      got_data_out <= tx_data_in;
      got_last_out <= tx_last_in;
    end
endmodule // cps_host_sink

/* File: verif/cps_sched_checker.sv */
`timescale 1ns/10ps
`include "cps_consts.vh"
module cps_sched_checker (
  // clock and reset
  input wire        sys_clk_in,
  input wire        resetn_in,
  // packet in
  input wire        rx_valid_in,
  input wire        rx_last_in,
  input wire        rx_ready_out,
  // status and settings
  input wire        accept_out,
  input wire        reject_out,
  input wire        save_req_out,
  input wire        tick_out,
  input wire        utc_sync_out,
  input wire [15:0] timer_period_out,
  input wire [31:0] baud_primary_out,
  input wire [31:0] baud_gpio_out,
  input wire [31:0] baud_aux_out,
  input wire [3:0]  retain_out
);
  wire last_tk = rx_valid_in & rx_ready_out & rx_last_in;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  property p_one_verdict; !(accept_out && reject_out); endproperty
  a_one_verdict: assert property (p_one_verdict)
    else $error("accept and reject together");
  property p_verdict_late;
    (accept_out || reject_out) |-> $past(last_tk, 2);
  endproperty
  a_verdict_late: assert property (p_verdict_late)
    else $error("verdict not tied to last byte");
  property p_save; save_req_out |-> accept_out; endproperty
  a_save: assert property (p_save)
    else $error("save request without accept");
  property p_tper; timer_period_out >= `CPS_TPER_MIN; endproperty
  a_tper: assert property (p_tper)
    else $error("timer period below minimum");
  property p_bpri; baud_primary_out >= `CPS_BAUD_MIN &&
    baud_primary_out <= `CPS_BAUD_PRI_MAX; endproperty
  a_bpri: assert property (p_bpri)
    else $error("primary baud out of range");
  property p_bga; baud_gpio_out <= `CPS_BAUD_GPIO_MAX &&
    baud_aux_out <= `CPS_BAUD_AUX_MAX && baud_aux_out >= `CPS_BAUD_MIN;
  endproperty
  a_bga: assert property (p_bga)
    else $error("gpio or aux baud out of range");
  property p_hold; reject_out |-> $stable(timer_period_out) &&
    $stable(baud_primary_out) && $stable(retain_out); endproperty
  a_hold: assert property (p_hold)
    else $error("settings moved on reject");
  property p_tchg;
    ($changed(timer_period_out) || $changed(utc_sync_out)) |-> accept_out;
  endproperty
  a_tchg: assert property (p_tchg)
    else $error("timer setting moved without accept");
  property p_rchg; $changed(retain_out) |-> accept_out; endproperty
  a_rchg: assert property (p_rchg)
    else $error("retention moved without accept");
  property p_tick; tick_out |=> !tick_out [*8]; endproperty
  a_tick: assert property (p_tick)
    else $error("tick longer than one cycle");
endmodule // cps_sched_checker

bind cps_sched cps_sched_checker u_chk (
  .sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
  .rx_valid_in(rx_valid_in), .rx_last_in(rx_last_in),
  .rx_ready_out(rx_ready_out), .accept_out(accept_out),
  .reject_out(reject_out), .save_req_out(save_req_out),
  .tick_out(tick_out), .utc_sync_out(utc_sync_out),
  .timer_period_out(timer_period_out), .baud_gpio_out(baud_gpio_out),
  .baud_primary_out(baud_primary_out), .baud_aux_out(baud_aux_out),
  .retain_out(retain_out));

/* File: verif/tb_top.sv */
`timescale 1ns/10ps
`include "cps_consts.vh"
module tb_top;
  logic        sys_clk_in   = 1'b0;
  logic        resetn_in    = 1'b0;
  logic        rx_valid_in  = 1'b0;
  logic [7:0]  rx_data_in   = 8'h00;
  logic        rx_last_in   = 1'b0;
  logic        pps_in       = 1'b0;
  logic [4:0]  align_idx_in = 5'h00;
  wire         rx_ready_out, tx_valid_out, tx_last_out, tx_ready_in;
  wire         accept_out, reject_out, save_req_out, tick_out;
  wire         emit_valid_out, utc_sync_out, got, got_last;
  wire [7:0]   tx_data_out, save_id_out, emit_id_out, got_data;
  wire [15:0]  timer_period_out;
  wire [31:0]  baud_primary_out, baud_gpio_out, baud_aux_out, align_word_out;
  wire [3:0]   retain_out;
  int          errors = 0;
  int          checks = 0;
  logic [7:0]  pkt[$];
  logic        exp_st[$];
  logic [8:0]  exp_tx[$];
  logic [31:0] aw[18];
  logic [15:0] v;
  always #2 sys_clk_in = ~sys_clk_in;
  cps_sched dut (.*, .ce_in(1'b1));
  cps_host_sink u_host (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .tx_valid_in(tx_valid_out), .tx_data_in(tx_data_out),
    .tx_last_in(tx_last_out), .tx_ready_out(tx_ready_in), .got_out(got),
    .got_data_out(got_data), .got_last_out(got_last));
  task cmp(input logic [31:0] g, input logic [31:0] e, input string m);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask
  task conclude;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task p32(input logic [31:0] w);
    for (int i = 0; i < 4; i++)
      pkt.push_back(w[8*i+:8]);
  endtask
  task xb(input logic [7:0] b, input logic l);
    exp_tx.push_back({l, b});
  endtask
  task send(input logic ok);
    int k;
    if (pkt.size() > 1)
      exp_st.push_back(ok);
    for (int i = 0; i < pkt.size(); i++)
    begin
      rx_valid_in <= 1'b1;
      rx_data_in  <= pkt[i];
      rx_last_in  <= (i == pkt.size() - 1);
      @(negedge sys_clk_in);
      while (rx_ready_out !== 1'b1)
        @(negedge sys_clk_in);
      @(posedge sys_clk_in);
    end
    rx_valid_in <= 1'b0;
    rx_last_in  <= 1'b0;
    pkt.delete();
    k = 0;
    while ((exp_st.size() != 0 || exp_tx.size() != 0) && k < 300)
    begin
      @(posedge sys_clk_in);
      k++;
    end
    if (k == 300) cmp(0, 1, "no answer");
    repeat (3) @(posedge sys_clk_in);
  endtask
  task rd5(input logic [7:0] id, input logic [7:0] per);
    xb(8'hB5, 0); xb(8'h00, 0); xb(8'h00, 0); xb(id, 0); xb(per, 0);
    xb(8'h00, 0); xb(8'h00, 0); xb(8'h00, 1);
    pkt = '{8'hB5};
    send(1'b1);
  endtask
  always @(posedge sys_clk_in)
  begin
    if (accept_out === 1'b1 || reject_out === 1'b1)
      cmp(accept_out, exp_st.size() ? exp_st.pop_front() : 1'bx,
          "verdict");
    if (got === 1'b1)
      cmp({got_last, got_data}, exp_tx.size() ? exp_tx.pop_front() : 9'h1FF,
          "answer byte");
  end
  initial
  begin
    #400000;
    errors++;
    conclude();
  end
  initial
  begin
    void'($urandom(32'h91CFFCB9));
    repeat (20) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    cmp(timer_period_out, `CPS_TPER_RST, "period at reset");
    cmp(baud_gpio_out, `CPS_BAUD_RST, "baud at reset");
    $display("reset test done");
    pkt = '{8'hB4, 8'h01, 8'h01, 8'h10, 8'h27};
    send(1'b1);
    cmp(timer_period_out, 16'h2710, "period");
    cmp(utc_sync_out, 1'b1, "utc lock");
    cmp(retain_out[0], 1'b1, "retained");
    pkt = '{8'hB4, 8'h00, 8'h00, 8'hE7, 8'h03};
    send(1'b0);
    pkt = '{8'hB4, 8'h00, 8'h02, 8'hE8, 8'h03};
    send(1'b0);
    pkt = '{8'hB4, 8'h02, 8'h00, 8'hE8, 8'h03};
    send(1'b0);
    pkt = '{8'hB4, 8'h00, 8'hE8, 8'h03};
    send(1'b0);
    pkt = '{8'hB7, 8'h00};
    send(1'b0);
    cmp(timer_period_out, 16'h2710, "period kept");
    v = 16'(1000 + ($urandom % 64536));
    pkt = '{8'hB4, 8'h00, 8'h00, v[7:0], v[15:8]};
    send(1'b1);
    cmp(timer_period_out, v, "random period");
    cmp(retain_out[0], 1'b0, "volatile");
    pkt = '{8'hB4, 8'h00, 8'h00, 8'hFF, 8'hFF};
    send(1'b1);
    xb(8'hB4, 0); xb(8'h00, 0); xb(8'h00, 0); xb(8'hFF, 0); xb(8'hFF, 1);
    pkt = '{8'hB4};
    send(1'b1);
    $display("timer test done");
    pkt = '{8'hB6, 8'h01};
    p32(32'h0098_9680); p32(32'h0000_0960); p32(32'h001E_8480);
    p32(32'h0000_0000);
    send(1'b1);
    cmp(baud_primary_out, 32'h0098_9680, "primary baud");
    cmp(baud_gpio_out, 32'h0000_0960, "gpio baud");
    cmp(baud_aux_out, 32'h001E_8480, "aux baud");
    cmp(retain_out[2], 1'b1, "baud retained");
    for (int i = 0; i < 4; i++)
    begin
      pkt = '{8'hB6, 8'h00};
      p32(i == 0 ? 32'h0098_9681 : 32'h0000_2580);
      p32(i == 1 ? 32'h0003_D091 : i == 2 ? 32'h0000_095F : 32'h0000_2580);
      p32(i == 3 ? 32'h001E_8481 : 32'h0000_2580);
      p32(32'h0000_0000);
      send(1'b0);
    end
    cmp(baud_aux_out, 32'h001E_8480, "aux kept");
    $display("baud test done");
    pkt = '{8'hB5, 8'h00, 8'h01, 8'h14};
    p32(32'h0000_0032);
    send(1'b1);
    pkt = '{8'hB5, 8'h00, 8'h00, 8'h14};
    p32(32'h0000_0007);
    send(1'b1);
    rd5(8'h14, 8'h07);
    pkt = '{8'hB5, 8'h00, 8'h01, 8'h1E};
    p32(32'h0000_0009);
    send(1'b1);
    rd5(8'h1E, 8'h09);
    pkt = '{8'hB5, 8'h00, 8'h00, 8'h14, 8'h01};
    send(1'b0);
    $display("period test done");
    pkt = '{8'hB9, 8'h00};
    for (int i = 0; i < 18; i++)
    begin
      aw[i] = $urandom;
      p32(aw[i]);
    end
    send(1'b1);
    for (int i = 0; i < 18; i++)
    begin
      align_idx_in <= 5'(i);
      @(posedge sys_clk_in);
      @(negedge sys_clk_in);
      cmp(align_word_out, aw[i], "alignment word");
      @(posedge sys_clk_in);
    end
    $display("alignment test done");
    conclude();
  end
endmodule // tb_top
